// file: core/otd_pkg.sv
package otd_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_VOLT_LOW   = 8'h76;
  localparam logic [7:0] IDX_TEMP_LOW   = 8'h77;
  localparam logic [7:0] IDX_CFG_THREE  = 8'h78;
  localparam logic [7:0] IDX_DUR_STATUS = 8'h79;
  localparam logic [7:0] IDX_DUR_LIMIT  = 8'h7a;
  localparam logic [7:0] IDX_MASK_TWO   = 8'h75;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h42;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h43;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h44;
  // High bytes of the five readings sit at consecutive indices from here
  localparam logic [7:0] IDX_HIGH_BASE  = 8'h20;
  localparam int         NUM_CHAN       = 5;

  // Channel numbers of the readings
  localparam int CH_V25    = 0;
  localparam int CH_VCC    = 1;
  localparam int CH_REMOTE1 = 2;
  localparam int CH_LOCAL  = 3;
  localparam int CH_REMOTE2 = 4;

  // Configuration three field positions
  localparam int CFG_ALERT = 0;
  localparam int CFG_MON   = 1;
  localparam int CFG_FULL_SPEED_ON_OVERTEMP = 2;
  localparam int CFG_FAST  = 3;
  localparam int CFG_CONT  = 4;

  localparam logic [7:0] CFG_THREE_RESET  = 8'h00;
  localparam logic [7:0] DUR_LIMIT_RESET  = 8'h00;
  localparam logic [7:0] MASK_TWO_RESET   = 8'h00;
  localparam logic [7:0] IRQ_RESET        = 8'h00;
  localparam logic [7:0] LIMIT_IMMEDIATE  = 8'h00;
  localparam logic [7:0] COUNT_MAX        = 8'hff;
  localparam int         IRQ_DUR_BIT      = 5;

  // Timing
  localparam longint CLOCK_PERIOD_NS = 10;
  localparam longint STEP_NS         = 22_760_000;
  localparam longint REPORT_NS       = 45_520_000;
  localparam int     STEP_CYCLES     = int'(STEP_NS / CLOCK_PERIOD_NS);
  localparam logic [7:0] REPORT_STEPS = 8'(REPORT_NS / STEP_NS);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         ADDR_W      = 12;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } otd_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } otd_axi_rsp_t;

  typedef struct packed {
    logic [9:0] remote_two;
    logic [9:0] local_sensor;
    logic [9:0] remote_one;
    logic [9:0] vcc;
    logic [9:0] v25;
  } otd_readings_t;

endpackage

// file: core/otd_sync.sv
`timescale 1ns/1ns
module otd_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  input  logic clock,
  input  logic rst,
  input  logic async_in,
  output logic sync_out
);
  logic stage_one;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage_one <= RESET_VALUE;
      sync_out  <= RESET_VALUE;
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule

// file: core/otd_step_timer.sv
`timescale 1ns/1ns
module otd_step_timer #(
  parameter int PERIOD = 4
) (
  input  logic clock,
  input  logic rst,
  input  logic run,
  output logic step
);
  logic [31:0] count;

  // Phase restarts whenever run drops, so each run measures from its own start
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      count <= 32'h0000_0000;
    else if (!run || count == 32'(PERIOD - 1))
      count <= 32'h0000_0000;
    else
      count <= count + 32'h0000_0001;
  end

  assign step = run && (count == 32'(PERIOD - 1));
endmodule

// file: core/otd_regs.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module otd_regs #(
  parameter int STEP_CYCLES = otd_pkg::STEP_CYCLES
) (
  input  logic                  clock,
  input  logic                  rst,
  input  otd_pkg::otd_axi_req_t axi_req,
  output otd_pkg::otd_axi_rsp_t axi_rsp,
  input  otd_pkg::otd_readings_t readings,
  input  logic                  overtemp_signal_n,
  input  logic [3:0]            fan_pwm_in,
  output logic [3:0]            fan_pwm_out,
  output logic                  pwm2_pin_out,
  output logic                  pwm2_pin_oe_n,
  output logic                  fast_fan_speed_pulse,
  output logic [3:0]            continuous_sense,
  output logic                  irq
);
  logic [7:0] cfg_three;
  logic [7:0] duration_limit_value;
  logic [7:0] mask_two;
  logic [7:0] irq_status;
  logic [7:0] irq_enable;
  logic [3:0] volt_low_spare;
  logic [1:0] temp_low_spare;
  logic [9:0] hold [otd_pkg::NUM_CHAN];
  logic [otd_pkg::NUM_CHAN-1:0] frozen;

  logic       ot_sync_n;
  logic       ot_active;
  logic       ot_prev;
  logic       ot_rise;
  logic       step;
  logic [7:0] cur_steps;
  logic [7:0] overtemp_duration_count;
  logic       assert_flag_count_lsb;
  logic       limit_done;
  logic       dur_event;
  logic [7:0] status_value;

  logic              aw_have;
  logic              w_have;
  logic [7:0]        aw_idx;
  logic              aw_bad;
  logic [31:0]       w_data;
  logic              w_lane0;
  logic              wr_go;
  logic              wr_ok;
  logic              rd_fire;
  logic [7:0]        rd_idx;
  logic              rd_ok;
  logic [7:0]        rd_value;
  logic              alert_active;
  logic [3:0]        next_fan_pwm;

  // Overtemperature pin is asynchronous and active low
  otd_sync #(
    .RESET_VALUE (1'b1)
  ) u_ot_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (overtemp_signal_n),
    .sync_out (ot_sync_n)
  );

  assign ot_active = cfg_three[otd_pkg::CFG_MON] && !ot_sync_n;
  assign ot_rise   = ot_active && !ot_prev;

  otd_step_timer #(
    .PERIOD (STEP_CYCLES)
  ) u_step (
    .clock (clock),
    .rst   (rst),
    .run   (ot_active),
    .step  (step)
  );

  // ---------------- AXI4-Lite slave ----------------
  assign axi_rsp.awready = !aw_have && !axi_rsp.bvalid;
  assign axi_rsp.wready  = !w_have && !axi_rsp.bvalid;
  assign axi_rsp.arready = !axi_rsp.rvalid;
  assign wr_go   = aw_have && w_have && !axi_rsp.bvalid;
  assign wr_ok   = wr_go && !aw_bad && w_lane0;
  assign rd_fire = axi_req.arvalid && axi_rsp.arready;
  assign rd_idx  = axi_req.araddr[9:2];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      aw_have <= 1'b0;
      aw_idx  <= 8'h00;
      aw_bad  <= 1'b0;
    end
    else if (axi_req.awvalid && axi_rsp.awready)
    begin
      aw_have <= 1'b1;
      aw_idx  <= axi_req.awaddr[9:2];
      aw_bad  <= (axi_req.awaddr[11:10] != 2'h0) || (axi_req.awaddr[1:0] != 2'h0);
    end
    else if (wr_go)
      aw_have <= 1'b0;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      w_have  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end
    else if (axi_req.wvalid && axi_rsp.wready)
    begin
      w_have  <= 1'b1;
      w_data  <= axi_req.wdata;
      w_lane0 <= axi_req.wstrb[0];
    end
    else if (wr_go)
      w_have <= 1'b0;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      axi_rsp.bvalid <= 1'b0;
      axi_rsp.bresp  <= otd_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      axi_rsp.bvalid <= 1'b1;
      axi_rsp.bresp  <= (aw_bad || !wr_known(aw_idx)) ? otd_pkg::RESP_SLVERR
                                                       : otd_pkg::RESP_OKAY;
    end
    else if (axi_req.bready)
      axi_rsp.bvalid <= 1'b0;
  end

  function automatic logic wr_known(input logic [7:0] idx);
    wr_known = (idx == otd_pkg::IDX_VOLT_LOW) || (idx == otd_pkg::IDX_TEMP_LOW) ||
               (idx == otd_pkg::IDX_CFG_THREE) || (idx == otd_pkg::IDX_DUR_LIMIT) ||
               (idx == otd_pkg::IDX_MASK_TWO) || (idx == otd_pkg::IDX_IRQ_CLEAR) ||
               (idx == otd_pkg::IDX_IRQ_ENABLE);
  endfunction

  // Read mux; unmapped or misaligned reads answer zero with an error
  always_comb
  begin
    rd_value = 8'h00;
    rd_ok    = 1'b1;
    unique case (rd_idx)
      otd_pkg::IDX_VOLT_LOW:
        // low bits of 2.5 V and supply
        rd_value = {volt_low_spare[3:2], hold[otd_pkg::CH_VCC][1:0],
                    volt_low_spare[1:0], hold[otd_pkg::CH_V25][1:0]};
      otd_pkg::IDX_TEMP_LOW:
        // low bits of the three temperatures
        rd_value = {hold[otd_pkg::CH_REMOTE2][1:0], hold[otd_pkg::CH_LOCAL][1:0],
                    hold[otd_pkg::CH_REMOTE1][1:0], temp_low_spare};
      otd_pkg::IDX_CFG_THREE:  rd_value = cfg_three;
      otd_pkg::IDX_DUR_STATUS: rd_value = status_value;
      otd_pkg::IDX_DUR_LIMIT:  rd_value = duration_limit_value;
      otd_pkg::IDX_MASK_TWO:   rd_value = mask_two;
      otd_pkg::IDX_IRQ_STATUS: rd_value = irq_status;
      otd_pkg::IDX_IRQ_ENABLE: rd_value = irq_enable;
      otd_pkg::IDX_IRQ_CLEAR:  rd_value = 8'h00;
      default:
      begin
        if (rd_idx >= otd_pkg::IDX_HIGH_BASE &&
            rd_idx < otd_pkg::IDX_HIGH_BASE + 8'(otd_pkg::NUM_CHAN))
          rd_value = hold[3'(rd_idx - otd_pkg::IDX_HIGH_BASE)][9:2];
        else
          rd_ok = 1'b0;
      end
    endcase
    if (axi_req.araddr[11:10] != 2'h0 || axi_req.araddr[1:0] != 2'h0)
    begin
      rd_ok    = 1'b0;
      rd_value = 8'h00;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      axi_rsp.rvalid <= 1'b0;
      axi_rsp.rdata  <= 32'h0000_0000;
      axi_rsp.rresp  <= otd_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      axi_rsp.rvalid <= 1'b1;
      axi_rsp.rdata  <= {24'h00_0000, rd_value};
      axi_rsp.rresp  <= rd_ok ? otd_pkg::RESP_OKAY : otd_pkg::RESP_SLVERR;
    end
    else if (axi_req.rready)
      axi_rsp.rvalid <= 1'b0;
  end

  // ---------------- Software registers ----------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cfg_three            <= otd_pkg::CFG_THREE_RESET;
      duration_limit_value <= otd_pkg::DUR_LIMIT_RESET;
      mask_two             <= otd_pkg::MASK_TWO_RESET;
      irq_enable           <= otd_pkg::IRQ_RESET;
      volt_low_spare       <= 4'h0;
      temp_low_spare       <= 2'h0;
    end
    else if (wr_ok)
    begin
      unique case (aw_idx)
        otd_pkg::IDX_CFG_THREE:  cfg_three <= w_data[7:0];
        otd_pkg::IDX_DUR_LIMIT:  duration_limit_value <= w_data[7:0];
        otd_pkg::IDX_MASK_TWO:   mask_two <= w_data[7:0];
        otd_pkg::IDX_IRQ_ENABLE: irq_enable <= w_data[7:0];
        otd_pkg::IDX_VOLT_LOW:   volt_low_spare <= {w_data[7:6], w_data[3:2]};
        otd_pkg::IDX_TEMP_LOW:   temp_low_spare <= w_data[1:0];
        default:                 cfg_three <= cfg_three;
      endcase
    end
  end

  // ---------------- Coherent readings ----------------
  // A channel is frozen from the read of its low bits until its high byte is read
  generate
    for (genvar ch = 0; ch < otd_pkg::NUM_CHAN; ch++)
    begin : g_chan
      logic low_read;
      logic high_read;
      logic [9:0] live;
      assign live      = readings[ch*10 +: 10];
      assign high_read = rd_fire && rd_idx == otd_pkg::IDX_HIGH_BASE + 8'(ch);
      assign low_read  = rd_fire && ((ch < 2) ? rd_idx == otd_pkg::IDX_VOLT_LOW
                                              : rd_idx == otd_pkg::IDX_TEMP_LOW);

      // freeze on low read, release on high read
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
          frozen[ch] <= 1'b0;
        else if (low_read)
          frozen[ch] <= 1'b1;
        else if (high_read)
          frozen[ch] <= 1'b0;
      end

      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
          hold[ch] <= 10'h000;
        else if (!frozen[ch] && !low_read)
          hold[ch] <= live;
      end

      chk_freeze_holds : assert property (@(posedge clock) disable iff (rst)
        frozen[ch] |=> $stable(hold[ch]))
        else $error("frozen reading changed");
    end
  endgenerate

  // ---------------- Overtemperature duration ----------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ot_prev <= 1'b0;
    else
      ot_prev <= ot_active;
  end

  // Steps of the current assertion, for the limit compare
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cur_steps <= 8'h00;
    else if (ot_rise)
      cur_steps <= 8'h00;
    else if (step && cur_steps != otd_pkg::COUNT_MAX)
      cur_steps <= cur_steps + 8'h01;
  end

  // accumulated count of steps, cleared by a status read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      overtemp_duration_count <= 8'h00;
    else if (rd_fire && rd_idx == otd_pkg::IDX_DUR_STATUS)
      overtemp_duration_count <= step ? 8'h01 : 8'h00;
    else if (step && overtemp_duration_count != otd_pkg::COUNT_MAX)
      overtemp_duration_count <= overtemp_duration_count + 8'h01;
  end

  // set on assertion, cleared on read; a new assertion wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      assert_flag_count_lsb <= 1'b0;
    else if (ot_rise)
      assert_flag_count_lsb <= 1'b1;
    else if (rd_fire && rd_idx == otd_pkg::IDX_DUR_STATUS)
      assert_flag_count_lsb <= 1'b0;
  end

  // upper bits stay zero until the report threshold
  assign status_value = (overtemp_duration_count >= otd_pkg::REPORT_STEPS)
                      ? overtemp_duration_count
                      : {7'h00, assert_flag_count_lsb};

  // one event per assertion once it outlasts the limit
  // a zero limit fires on the assertion edge itself
  assign dur_event = ot_active && !limit_done &&
                     (duration_limit_value == otd_pkg::LIMIT_IMMEDIATE ||
                      cur_steps > duration_limit_value);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      limit_done <= 1'b0;
    else if (!ot_active)
      limit_done <= 1'b0;
    else if (dur_event)
      limit_done <= 1'b1;
  end

  // ---------------- Interrupts ----------------
  // Status is sticky; write-one-to-clear, and a same-cycle event wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_status <= otd_pkg::IRQ_RESET;
    else
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (b == otd_pkg::IRQ_DUR_BIT && dur_event)
          irq_status[b] <= 1'b1;
        else if (wr_ok && aw_idx == otd_pkg::IDX_IRQ_CLEAR && w_data[b])
          irq_status[b] <= 1'b0;
      end
    end
  end

  // mask bit 5 hides the duration event from the alert
  assign alert_active = irq_status[otd_pkg::IRQ_DUR_BIT] && !mask_two[otd_pkg::IRQ_DUR_BIT];

  assign next_fan_pwm = (cfg_three[otd_pkg::CFG_FULL_SPEED_ON_OVERTEMP] && ot_active) ? 4'hf : fan_pwm_in;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      fan_pwm_out      <= 4'h0;
      pwm2_pin_out     <= 1'b0;
      pwm2_pin_oe_n    <= 1'b1;
      fast_fan_speed_pulse        <= 1'b0;
      continuous_sense <= 4'h0;
      irq              <= 1'b0;
    end
    else
    begin
      fan_pwm_out <= next_fan_pwm;
      // open-drain alert when selected, otherwise the fan two drive
      if (cfg_three[otd_pkg::CFG_ALERT])
      begin
        pwm2_pin_out  <= 1'b0;
        pwm2_pin_oe_n <= !alert_active;
      end
      else
      begin
        pwm2_pin_out  <= next_fan_pwm[1];
        pwm2_pin_oe_n <= 1'b0;
      end
      fast_fan_speed_pulse        <= cfg_three[otd_pkg::CFG_FAST];
      continuous_sense <= cfg_three[otd_pkg::CFG_CONT +: 4];
      irq              <= |(irq_status & irq_enable);
    end
  end

  // ---------------- Checks ----------------
  sequence s_status_read;
    rd_fire && rd_idx == otd_pkg::IDX_DUR_STATUS;
  endsequence

  sequence s_ot_start;
    ot_rise;
  endsequence

  chk_cfg_reset_zero : assert property (@(posedge clock)
    $fell(rst) |-> cfg_three == otd_pkg::CFG_THREE_RESET && !fast_fan_speed_pulse)
    else $error("config three not zero after reset");

  chk_low_one_data : assert property (@(posedge clock) disable iff (rst)
    rd_fire && rd_idx == otd_pkg::IDX_VOLT_LOW && rd_ok |=>
      axi_rsp.rdata[1:0] == $past(hold[otd_pkg::CH_V25][1:0]) &&
      axi_rsp.rdata[5:4] == $past(hold[otd_pkg::CH_VCC][1:0]))
    else $error("low bits one wrong");

  chk_low_two_data : assert property (@(posedge clock) disable iff (rst)
    rd_fire && rd_idx == otd_pkg::IDX_TEMP_LOW && rd_ok |=>
      axi_rsp.rdata[7:6] == $past(hold[otd_pkg::CH_REMOTE2][1:0]) &&
      axi_rsp.rdata[3:2] == $past(hold[otd_pkg::CH_REMOTE1][1:0]))
    else $error("low bits two wrong");

  chk_full_speed_on_overtemp_full : assert property (@(posedge clock) disable iff (rst)
    cfg_three[otd_pkg::CFG_FULL_SPEED_ON_OVERTEMP] && ot_active |=> fan_pwm_out == 4'hf)
    else $error("full_speed_on_overtemp did not force full duty");

  chk_alert_drive : assert property (@(posedge clock) disable iff (rst)
    cfg_three[otd_pkg::CFG_ALERT] && alert_active |=> !pwm2_pin_oe_n && !pwm2_pin_out)
    else $error("alert not driven");

  chk_flag_set : assert property (@(posedge clock) disable iff (rst)
    s_ot_start |=> assert_flag_count_lsb ##1 (assert_flag_count_lsb || $past(rd_fire)))
    else $error("assert flag not set");

  chk_flag_clear : assert property (@(posedge clock) disable iff (rst)
    s_status_read and !ot_rise |=> !assert_flag_count_lsb)
    else $error("assert flag not cleared by read");

  // Checked at the bus so that the read mux is covered too
  chk_upper_zero : assert property (@(posedge clock) disable iff (rst)
    s_status_read and overtemp_duration_count < otd_pkg::REPORT_STEPS
      |=> axi_rsp.rdata[7:1] == 7'h00)
    else $error("upper duration bits early");

  chk_limit_zero : assert property (@(posedge clock) disable iff (rst)
    s_ot_start and duration_limit_value == otd_pkg::LIMIT_IMMEDIATE
      |=> irq_status[otd_pkg::IRQ_DUR_BIT])
    else $error("zero limit did not fire");

  chk_limit_event : assert property (@(posedge clock) disable iff (rst)
    ot_active && !limit_done && cur_steps > duration_limit_value
      |=> irq_status[otd_pkg::IRQ_DUR_BIT] && limit_done)
    else $error("limit overrun not flagged");

  chk_count_saturate : assert property (@(posedge clock) disable iff (rst)
    overtemp_duration_count == otd_pkg::COUNT_MAX && !rd_fire
      |=> overtemp_duration_count == otd_pkg::COUNT_MAX)
    else $error("duration count wrapped");

  chk_fast_cont : assert property (@(posedge clock) disable iff (rst)
    $changed(cfg_three) |=> fast_fan_speed_pulse == $past(cfg_three[otd_pkg::CFG_FAST]) &&
      continuous_sense == $past(cfg_three[7:4]))
    else $error("fan_speed_pulse selects do not follow config");

  chk_monitor_gate : assert property (@(posedge clock) disable iff (rst)
    !cfg_three[otd_pkg::CFG_MON] |-> !ot_active && !dur_event)
    else $error("overtemperature seen while disabled");

  chk_mask_alert : assert property (@(posedge clock) disable iff (rst)
    cfg_three[otd_pkg::CFG_ALERT] && mask_two[otd_pkg::IRQ_DUR_BIT]
      && $stable(cfg_three) |=> pwm2_pin_oe_n)
    else $error("masked duration event drove alert");

endmodule

// file: verification/otd_host.sv
`timescale 1ns/1ns
module otd_host (
  input  logic                  clock,
  output otd_pkg::otd_axi_req_t req,
  input  otd_pkg::otd_axi_rsp_t rsp
);
  initial req = '0;
  // Payload is inverted once released so stale values cannot pass
  task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.awaddr  <= {2'b00, i, 2'b00};
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h00_0000, d};
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end
    while (!rsp.bvalid);
    req.bready <= 1'b0;
    req.awaddr <= ~req.awaddr;
    req.wdata  <= ~req.wdata;
    r = rsp.bresp;
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d, output logic [1:0] r);
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr  <= {2'b00, i, 2'b00};
    req.rready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    while (!rsp.rvalid);
    req.rready <= 1'b0;
    req.araddr <= ~req.araddr;
    d = rsp.rdata[7:0];
    r = rsp.rresp;
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  localparam int SC = 8;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wval;
    logic [7:0] rval;
    logic [1:0] resp;
  } otd_row_t;
  logic                   clock = 1'b0;
  logic                   rst = 1'b1;
  otd_pkg::otd_axi_req_t  req;
  otd_pkg::otd_axi_rsp_t  rsp;
  otd_pkg::otd_readings_t readings = '0;
  logic                   ot_n = 1'b1;
  logic [3:0]             pwm_in = 4'h9;
  logic [3:0]             pwm_out;
  logic                   pin;
  logic                   pin_oe_n;
  logic                   fast;
  logic [3:0]             cont;
  logic                   irq;
  logic [7:0]             d;
  logic [1:0]             r;
  int                     mismatches = 0;
  int                     samples_checked = 0;
  otd_row_t               rows [5] = '{
    '{8'h78, 8'ha8, 8'ha8, 2'h0},
    '{8'h78, 8'h50, 8'h50, 2'h0},
    '{8'h7a, 8'h3c, 8'h3c, 2'h0},
    '{8'h79, 8'hff, 8'h00, 2'h2},
    '{8'h10, 8'h55, 8'h00, 2'h2}};
  always #5 clock = ~clock;
  otd_host u_host (
    .clock (clock),
    .req   (req),
    .rsp   (rsp)
  );
  otd_regs #(.STEP_CYCLES(SC)) u_dut (
    .clock             (clock),
    .rst               (rst),
    .axi_req           (req),
    .axi_rsp           (rsp),
    .readings          (readings),
    .overtemp_signal_n (ot_n),
    .fan_pwm_in        (pwm_in),
    .fan_pwm_out       (pwm_out),
    .pwm2_pin_out      (pin),
    .pwm2_pin_oe_n     (pin_oe_n),
    .fast_fan_speed_pulse         (fast),
    .continuous_sense  (cont),
    .irq               (irq)
  );
  task automatic go(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Pin is asserted n+1 cycles; the sync delays both edges alike
  task automatic hold(input int n, input logic [3:0] pwm);
    @(posedge clock);
    ot_n <= 1'b0;
    go(n);
    #1;
    `CHK(pwm_out, pwm)
    go(1);
    ot_n <= 1'b1;
    go(6);
  endtask
  task automatic chk_irq(input logic e);
    go(2);
    #1;
    `CHK(irq, e)
  endtask
  initial
  begin
    go(10000);
    mismatches++;
    final_report;
  end
  initial
  begin
    go(2);
    rst <= 1'b0;
    foreach (rows[k])
    begin
      u_host.wr(rows[k].idx, rows[k].wval, r);
      `CHK(r, rows[k].resp)
      u_host.rd(rows[k].idx, d, r);
      `CHK(d, rows[k].rval)
      go(2);
      #1;
      if (rows[k].idx == 8'h78) `CHK({cont, fast}, {rows[k].wval[7:4], rows[k].wval[3]})
    end
    $display("test table done");
    go(1);
    rst <= 1'b1;
    go(1);
    #1;
    `CHK({pin_oe_n, fast, cont, irq}, 7'h40)
    go(1);
    rst <= 1'b0;
    for (int i = 8'h78; i <= 8'h7a; i++)
    begin
      u_host.rd(8'(i), d, r);
      `CHK(d, 8'h00)
    end
    $display("test reset done");
    readings <= {10'h001, 10'h102, 10'h3ff, 10'h1a1, 10'h2c6};
    go(3);
    u_host.rd(8'h76, d, r);
    `CHK(d & 8'h33, 8'h12)
    readings.v25 <= 10'h001;
    go(3);
    u_host.rd(8'h20, d, r);
    `CHK(d, 8'hb1)
    u_host.rd(8'h20, d, r);
    `CHK(d, 8'h00)
    u_host.rd(8'h77, d, r);
    `CHK(d & 8'hfc, 8'h6c)
    $display("test low bits done");
    u_host.wr(8'h78, 8'h04, r);
    hold(5, 4'h9);
    u_host.rd(8'h79, d, r);
    `CHK(d, 8'h00)
    u_host.wr(8'h44, 8'h20, r);
    u_host.wr(8'h7a, 8'h02, r);
    u_host.wr(8'h78, 8'h06, r);
    hold(5, 4'hf);
    u_host.rd(8'h79, d, r);
    `CHK(d, 8'h01)
    u_host.rd(8'h79, d, r);
    `CHK(d, 8'h00)
    hold(11, 4'hf);
    u_host.rd(8'h79, d, r);
    `CHK(d, 8'h01)
    chk_irq(1'b0);
    hold(43, 4'hf);
    u_host.rd(8'h79, d, r);
    `CHK(d, 8'h05)
    chk_irq(1'b1);
    u_host.rd(8'h42, d, r);
    `CHK(d[5], 1'b1)
    u_host.wr(8'h44, 8'h00, r);
    chk_irq(1'b0);
    u_host.wr(8'h44, 8'h20, r);
    chk_irq(1'b1);
    u_host.wr(8'h78, 8'h07, r);
    go(2);
    #1;
    `CHK({pin, pin_oe_n}, 2'b00)
    u_host.wr(8'h75, 8'h20, r);
    go(2);
    #1;
    `CHK(pin_oe_n, 1'b1)
    u_host.wr(8'h43, 8'h20, r);
    chk_irq(1'b0);
    u_host.wr(8'h7a, 8'h00, r);
    hold(3, 4'hf);
    #1;
    `CHK(irq, 1'b1)
    hold(2100, 4'hf);
    u_host.rd(8'h79, d, r);
    `CHK(d, 8'hff)
    $display("test overtemp done");
    final_report;
  end
endmodule
